// file: hdl/eeprom_status_regs.svh
`ifndef EEPROM_STATUS_REGS_SVH
`define EEPROM_STATUS_REGS_SVH
// ****************
// Command codes and field positions
// ****************
`define CMD_STATUS_READ 8'h05
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define BIT_LOCK 7
`define SHIFT_HI 6
`define CNT_STEP 3'h1
`define BIT_WEL 1
`define BIT_WIP 0
`define RSV_SMALL 4'hF
`define RSV_LARGE 3'h0
`define BITS_LAST 3'h7
`define BITS_ZERO 3'h0
`define BYTE_ZERO 8'h00
`endif

// file: hdl/eeprom_status_pkg.sv
`default_nettype none
package eeprom_status_pkg;
  // Serial frame phase
  typedef enum logic [1:0] {PH_CMD, PH_STATUS, PH_IGNORE} phase_t;
  // Status fields coming from the rest of the device
  typedef struct packed {
    logic [1:0] protect_field;
    logic status_write_lock;
    logic write_in_progress;
  } status_src_t;
endpackage : eeprom_status_pkg
`default_nettype wire

// file: hdl/spi_eeprom_status_read.sv
`include "eeprom_status_regs.svh"
`default_nettype none
// ****************
// Status-read slave of a serial EEPROM
// ****************
// The host owns sck and cs_b; this block oversamples both on clk, so each
// sck phase must last at least one clk period or an edge is lost.
// Only the status-read path lives here. The two latch commands are decoded
// as well, because the latch is one bit of the returned status byte.
module spi_eeprom_status_read #(
  // Density select: 1 for parts above 4 Kbit, 0 for 4 Kbit and below
  parameter bit LARGE_PART = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // SPI pins, sampled synchronously to clk
  input wire logic cs_b,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Device state
  input wire eeprom_status_pkg::status_src_t status_src,
  output logic write_enable_latch
);

  // ****************
  // Command decoding
  // ****************
  // Each compare is used in one place only, but is still written as a function here

  // Status-read command
  function automatic logic is_status_read(input logic [7:0] code);
    return code == `CMD_STATUS_READ;
  endfunction : is_status_read

  // Write-enable command
  function automatic logic is_write_enable(input logic [7:0] code);
    return code == `CMD_WRITE_ENABLE;
  endfunction : is_write_enable

  // Write-disable command
  function automatic logic is_write_disable(input logic [7:0] code);
    return code == `CMD_WRITE_DISABLE;
  endfunction : is_write_disable

  // ****************
  // State and next values
  // ****************
  // Registered state
  logic sck_q_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] out_ff;
  eeprom_status_pkg::phase_t phase_ff;
  // Next values, one per register
  logic nxt_sck_q;
  logic [2:0] nxt_bit_cnt;
  logic [7:0] nxt_shift;
  logic [7:0] nxt_out;
  eeprom_status_pkg::phase_t nxt_phase;
  logic nxt_wel;
  logic nxt_miso;
  logic nxt_miso_oe;

  // ****************
  // Serial clock edge detection
  // ****************
  // Edges count only inside a frame, so stray sck toggles while the part
  // is deselected cannot shift anything in or out
  wire logic sck_rise;
  wire logic sck_fall;
  assign sck_rise = sck & ~sck_q_ff & ~cs_b;
  assign sck_fall = ~sck & sck_q_ff & ~cs_b;
  assign nxt_sck_q = sck; // Idle level of sck in mode 0 is low, as after reset

  // ****************
  // Command byte assembly
  // ****************
  // The byte under assembly includes the bit arriving on this rise, so a
  // complete command is visible in the same cycle as its eighth edge
  wire logic [7:0] cmd_byte;
  wire logic byte_done;
  wire logic cmd_phase;
  wire logic cmd_done;
  wire logic cmd_is_read;
  assign cmd_byte = {shift_ff[`SHIFT_HI:0], mosi};
  assign byte_done = sck_rise & (bit_cnt_ff == `BITS_LAST);
  assign cmd_phase = (phase_ff == eeprom_status_pkg::PH_CMD);
  assign cmd_done = byte_done & cmd_phase;
  assign cmd_is_read = is_status_read(cmd_byte);

  // Bit counter and input shifter; a partial byte is dropped at deselect
  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    if (cs_b) begin
      nxt_bit_cnt = `BITS_ZERO;
    end else if (sck_rise) begin
      nxt_bit_cnt = bit_cnt_ff + `CNT_STEP; // Wraps after eight bits on purpose
      nxt_shift = cmd_byte;
    end
  end

  // ****************
  // Frame sequencing
  // ****************
  // One command per frame: after the status byte, further clocks are ignored
  // until chip select goes high again
  always_comb begin
    nxt_phase = phase_ff;
    if (cs_b) begin
      nxt_phase = eeprom_status_pkg::PH_CMD;
    end else if (byte_done) begin
      unique case (phase_ff)
        eeprom_status_pkg::PH_CMD: begin
          nxt_phase = cmd_is_read ? eeprom_status_pkg::PH_STATUS : eeprom_status_pkg::PH_IGNORE;
        end
        eeprom_status_pkg::PH_STATUS: begin
          nxt_phase = eeprom_status_pkg::PH_IGNORE;
        end
        eeprom_status_pkg::PH_IGNORE: begin
          nxt_phase = eeprom_status_pkg::PH_IGNORE;
        end
        default: begin
          // The unused fourth code falls back to a harmless state
          nxt_phase = eeprom_status_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // ****************
  // Status assembly
  // ****************
  // Reserved bits differ by density; they are fixed by parameter because a
  // given part never changes density at run time
  wire logic [7:0] status_large;
  wire logic [7:0] status_small;
  wire logic [7:0] status_byte;
  assign status_large = {
    status_src.status_write_lock,
    `RSV_LARGE,
    status_src.protect_field,
    write_enable_latch,
    status_src.write_in_progress
  };
  assign status_small = {
    `RSV_SMALL,
    status_src.protect_field,
    write_enable_latch,
    status_src.write_in_progress
  };
  assign status_byte = LARGE_PART ? status_large : status_small;

  // ****************
  // Write-enable latch
  // ****************
  // Latch changes only once a whole command byte is in; a cut frame leaves it alone
  always_comb begin
    nxt_wel = write_enable_latch;
    if (cmd_done && is_write_enable(cmd_byte)) begin
      nxt_wel = 1'b1;
    end else if (cmd_done && is_write_disable(cmd_byte)) begin
      nxt_wel = 1'b0;
    end
  end

  // ****************
  // Serial output
  // ****************
  // Status is snapshotted at the end of the command so the byte cannot tear
  // if a field changes mid-transfer; later bits move on sck falls, MSB first
  wire logic load_status;
  wire logic shift_status;
  wire logic status_phase;
  assign status_phase = (phase_ff == eeprom_status_pkg::PH_STATUS);
  assign load_status = cmd_done & cmd_is_read;
  assign shift_status = sck_fall & status_phase & (bit_cnt_ff != `BITS_ZERO);

  // Output next values; the first fall after the command keeps bit seven
  always_comb begin
    nxt_out = out_ff;
    nxt_miso = miso;
    nxt_miso_oe = miso_oe;
    if (cs_b) begin
      nxt_miso = 1'b0;
      nxt_miso_oe = 1'b0;
    end else if (load_status) begin
      nxt_out = {status_byte[`SHIFT_HI:0], 1'b0};
      nxt_miso = status_byte[`BIT_LOCK];
      nxt_miso_oe = 1'b1;
    end else if (shift_status) begin
      nxt_miso = out_ff[`BIT_LOCK];
      nxt_out = {out_ff[`SHIFT_HI:0], 1'b0};
    end else if (phase_ff == eeprom_status_pkg::PH_IGNORE) begin
      nxt_miso_oe = 1'b0;
    end
  end

  // ****************
  // Registers
  // ****************
  // Edge detector history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= nxt_sck_q;
    end
  end

  // Input side of the frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_ff <= `BITS_ZERO;
      shift_ff <= `BYTE_ZERO;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Frame phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= eeprom_status_pkg::PH_CMD;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Write-enable latch, cleared by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch <= 1'b0;
    end else begin
      write_enable_latch <= nxt_wel;
    end
  end

  // Output shifter and pin drivers; the pin is quiet during reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ff <= `BYTE_ZERO;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      miso <= nxt_miso;
      miso_oe <= nxt_miso_oe;
    end
  end
endmodule : spi_eeprom_status_read
`default_nettype wire

// file: test/st_sva.sv
`default_nettype none
module st_sva #(
  parameter bit LARGE_PART = 1'b1
) (
  input wire logic clk, rst_b, cs_b, sck, miso, miso_oe, write_enable_latch,
  input wire eeprom_status_pkg::status_src_t status_src
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_start; $rose(miso_oe); endsequence
  sequence s_drive; miso_oe && $past(miso_oe) && sck && $past(sck); endsequence
  property p_go; s_start |-> $past(sck) && !$past(sck, 2); endproperty
  a_go: assert property (p_go) else $error("late");
  property p_b7; s_start |-> miso == (LARGE_PART ? status_src.status_write_lock : 1'b1); endproperty
  a_b7: assert property (p_b7) else $error("bit7");
  property p_wl; $changed(write_enable_latch) |-> !miso_oe; endproperty
  a_wl: assert property (p_wl) else $error("latch");
  property p_idle; cs_b |=> !miso_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_hold; s_drive |-> $stable(miso); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_len; s_start |-> miso_oe [*8]; endproperty
  a_len: assert property (p_len) else $error("short");
endmodule : st_sva
bind spi_eeprom_status_read st_sva #(.LARGE_PART(LARGE_PART)) sva (.*);
`default_nettype wire

// file: test/spi_host.sv
`default_nettype none
module spi_host (input wire logic clk, miso, miso_oe, output logic cs_b = 1'h1, sck = 1'h0, mosi = 1'h0);
  timeunit 1ns;
  timeprecision 1ns;
  // Slack at both cs_b edges
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
    cs_b <= 1'h0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= i > 7 ? cmd[i - 8] : ~mosi;
      repeat (3) @(posedge clk);
      sck <= 1'h1;
      repeat (2) @(posedge clk);
      if (i < 8) rx[i] = miso;
      sck <= 1'h0;
    end
    repeat (3) @(posedge clk);
    cs_b <= 1'h1;
    repeat (3) @(posedge clk);
  endtask : xfer
endmodule : spi_host
`default_nettype wire

// file: test/tb.sv
`include "eeprom_status_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_b = 1'h0, cs_b, sck, mosi, miso, miso_oe, write_enable_latch;
  logic cs_b_s, sck_s, mosi_s, miso_s, miso_oe_s, wel_s;
  logic [7:0] rx;
  eeprom_status_pkg::status_src_t status_src = '0;
  int err_total = 0, checked = 0;
  always #25 clk = ~clk;
  spi_eeprom_status_read dut (.*);
  spi_host host (.*);
  // Small-density part on its own pins
  spi_eeprom_status_read #(.LARGE_PART(1'b0)) dut_small (.clk(clk), .rst_b(rst_b), .cs_b(cs_b_s), .sck(sck_s),
    .mosi(mosi_s), .miso(miso_s), .miso_oe(miso_oe_s), .status_src(status_src), .write_enable_latch(wel_s));
  spi_host host_s (.clk(clk), .miso(miso_s), .miso_oe(miso_oe_s), .cs_b(cs_b_s), .sck(sck_s), .mosi(mosi_s));
  task automatic check(input string what, input logic [7:0] want, input logic [7:0] seen);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    for (logic [3:0] k = 4'h0; k < 4'h8; k++) begin
      @(posedge clk);
      status_src <= '{k[1:0], k[2], ^k[1:0]};
      host.xfer(k[0] ? `CMD_WRITE_ENABLE : `CMD_WRITE_DISABLE, rx);
      check("latch", {7'h00, k[0]}, {7'h00, write_enable_latch});
      host.xfer(`CMD_STATUS_READ, rx);
      check("status_large", {k[2], 3'h0, k[1:0], k[0], ^k[1:0]}, rx);
      host_s.xfer(k[0] ? `CMD_WRITE_ENABLE : `CMD_WRITE_DISABLE, rx);
      check("latch_small", {7'h00, k[0]}, {7'h00, wel_s});
      host_s.xfer(`CMD_STATUS_READ, rx);
      check("status_small", {4'hF, k[1:0], k[0], ^k[1:0]}, rx);
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
